//--- logic/core_arith_transfer_decode.sv
/*
  Opcode decoder and execution timing for the pointer-load, frame, flag-transfer,
  add, subtract, compare, adjust and multiply instructions of a 16-bit core.
  Assumes instruction bytes arrive in order from the prefetch path under valid/ready.
*/
// Notes on behaviour
// - Slash timings give register count first, memory count second; accumulator forms give byte, then word.
// - Opcode 8D with operand byte decodes as load_effective_offset, 6 clocks.
// - Opcodes C5/C4 load far pointer, 18 clocks; register form is invalid.
// - Opcode C8 builds frame: 15, 25, or 22+16(n-1) clocks by level.
// - Opcode C9 tears down the frame in 8 clocks.
// - Opcode 9F takes 2 clocks, opcode 9E takes 3 clocks.
// - Two-operand register/memory arithmetic takes 3 clocks register, 10 memory.
// - Group 100000sw picks operation by middle field; two data bytes when sw=01.
// - Opcode 0000010w adds immediate to accumulator; 3 clocks byte, 4 word.
// - add_with_carry uses 000100dw, group field 010, and 0001010w.
// - Opcode 37 is ascii_sum_adjust, 8 clocks.
// - Opcode 27 is bcd_sum_adjust, 4 clocks.
// - minus_op uses 001010dw and group field 101; immediate 4 or 16 clocks.
// - borrow_minus_op uses 000110dw and group field 011, same timings.
// - compare_op register forms 0011101w/0011100w take 3 or 10 clocks.
// - compare_op group field 111 takes 3/10; accumulator 0011110w takes 3/4.
// - Opcode 3F is ascii_minus_adjust, 7 clocks.
// - Opcode 2F is bcd_minus_adjust, 4 clocks.
// - unsigned_product is 1111011w field 100 with its four timing ranges.
// - signed_product is 1111011w field 101 with its four timing ranges.
// - Opcode 011010s1 multiplies by immediate; second byte when s=0; 25/32 clocks.
// - A mod 01 displacement byte is sign-extended to 16 bits.
`timescale 1ns/100ps
module core_arith_transfer_decode
  import core_decode_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Instruction byte stream.
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  // Decode result.
  output logic             dec_valid,
  output decode_result_type dec_result,
  // Execution timing.
  output logic             exec_busy,
  output logic             exec_done
);

  typedef enum logic [2:0] {
    ST_OPC     = 3'h0,
    ST_MODRM   = 3'h1,
    ST_DISP    = 3'h3,
    ST_DATA    = 3'h2,
    ST_RESOLVE = 3'h6,
    ST_EXEC    = 3'h7
  } state_type;

  state_type         state_ff, nxt_state;
  logic [7:0]        opc_ff, nxt_opc;
  logic [7:0]        modrm_ff, nxt_modrm;
  logic [15:0]       disp_ff, nxt_disp;
  logic [23:0]       imm_ff, nxt_imm;
  logic [1:0]        idx_ff, nxt_idx;
  opc_info_type      info_ff, nxt_info;
  decode_result_type res_ff, nxt_res;
  logic              valid_ff, nxt_valid;
  logic [7:0]        len_src;
  logic [1:0]        disp_bytes;
  logic              mem_op;
  logic              take;
  logic              timer_start;
  opc_info_type      cur_info;

  function automatic opc_info_type classify(input logic [7:0] opc);
    opc_info_type i;
    i = '{known: 1'b1, op: OP_NONE, form: FORM_FIXED, has_modrm: 1'b0, imm_bytes: 2'h0};
    if (opc == OPC_LEA) begin
      i.op = OP_LEA;
      i.has_modrm = 1'b1;
    end else if (opc == OPC_LDS || opc == OPC_LES) begin
      i.op = (opc == OPC_LDS) ? OP_LDS : OP_LES;
      i.has_modrm = 1'b1;
    // frame size word then level byte.
    end else if (opc == OPC_ENTER) begin
      i.op = OP_ENTER;
      i.imm_bytes = 2'h3;
    end else if (opc == OPC_LEAVE) begin
      i.op = OP_LEAVE;
    end else if (opc == OPC_FLAGS_TO_HIGH_ACC) begin
      i.op = OP_FLAGS_TO_HIGH_ACC;
    end else if (opc == OPC_HIGH_ACC_TO_FLAGS) begin
      i.op = OP_HIGH_ACC_TO_FLAGS;
    end else if (opc == OPC_AAA) begin
      i.op = OP_AAA;
    end else if (opc == OPC_DAA) begin
      i.op = OP_DAA;
    end else if (opc == OPC_AAS) begin
      i.op = OP_AAS;
    end else if (opc == OPC_DAS) begin
      i.op = OP_DAS;
    end else if (opc[7:2] == TOP6_ADD_RM || opc[7:2] == TOP6_ADC_RM ||
                 opc[7:2] == TOP6_SUB_RM || opc[7:2] == TOP6_SBB_RM ||
                 opc[7:2] == TOP6_CMP_RM) begin
      i.form = FORM_RM;
      i.has_modrm = 1'b1;
      case (opc[7:2])
        TOP6_ADD_RM: i.op = OP_ADD;
        TOP6_ADC_RM: i.op = OP_ADC;
        TOP6_SUB_RM: i.op = OP_SUB;
        TOP6_SBB_RM: i.op = OP_SBB;
        default:     i.op = OP_CMP;
      endcase
    // immediate group, operation chosen later by the middle field.
    end else if (opc[7:2] == TOP6_IMM_GRP) begin
      i.form = FORM_IMM_RM;
      i.has_modrm = 1'b1;
      i.imm_bytes = (opc[1:0] == SW_WORD_TWO_BYTES) ? 2'h2 : 2'h1;
    end else if (opc[7:1] == TOP7_ADD_ACC || opc[7:1] == TOP7_ADC_ACC ||
                 opc[7:1] == TOP7_CMP_ACC) begin
      i.form = FORM_IMM_ACC;
      i.imm_bytes = opc[0] ? 2'h2 : 2'h1;
      i.op = (opc[7:1] == TOP7_ADD_ACC) ? OP_ADD :
             (opc[7:1] == TOP7_ADC_ACC) ? OP_ADC : OP_CMP;
    end else if (opc[7:1] == TOP7_MUL_GRP) begin
      i.op = OP_MUL_GRP;
      i.has_modrm = 1'b1;
    // second data byte only when s is clear.
    end else if (opc[7:2] == TOP6_SIGNED_PRODUCT_IMM && opc[0]) begin
      i.op = OP_SIGNED_PRODUCT_IMM;
      i.has_modrm = 1'b1;
      i.imm_bytes = opc[1] ? 2'h1 : 2'h2;
    end else begin
      i.known = 1'b0;
    end
    return i;
  endfunction

  assign cur_info = classify(byte_data);
  assign len_src  = (state_ff == ST_MODRM) ? byte_data : modrm_ff;
  assign take     = byte_valid && byte_ready;

  operand_len u_operand_len (
    .modrm      (len_src),
    .disp_bytes (disp_bytes),
    .mem_op     (mem_op)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_opc   = opc_ff;
    nxt_modrm = modrm_ff;
    nxt_disp  = disp_ff;
    nxt_imm   = imm_ff;
    nxt_idx   = idx_ff;
    nxt_info  = info_ff;
    case (state_ff)
      ST_OPC: if (take) begin
        nxt_opc   = byte_data;
        nxt_info  = cur_info;
        nxt_modrm = 8'hc0;
        nxt_disp  = 16'h0000;
        nxt_imm   = 24'h00_0000;
        nxt_idx   = 2'h0;
        nxt_state = (!cur_info.known || !(cur_info.has_modrm || cur_info.imm_bytes != 2'h0)) ?
                    ST_RESOLVE : (cur_info.has_modrm ? ST_MODRM : ST_DATA);
      end
      ST_MODRM: if (take) begin
        nxt_modrm = byte_data;
        nxt_state = (disp_bytes != 2'h0) ? ST_DISP :
                    (info_ff.imm_bytes != 2'h0) ? ST_DATA : ST_RESOLVE;
      end
      ST_DISP: if (take) begin
        nxt_disp[8*idx_ff[0] +: 8] = byte_data;
        nxt_idx = idx_ff + 2'h1;
        if (idx_ff + 2'h1 == disp_bytes) begin
          nxt_idx   = 2'h0;
          nxt_state = (info_ff.imm_bytes != 2'h0) ? ST_DATA : ST_RESOLVE;
        end
      end
      ST_DATA: if (take) begin
        nxt_imm[8*idx_ff +: 8] = byte_data;
        nxt_idx = idx_ff + 2'h1;
        if (idx_ff + 2'h1 == info_ff.imm_bytes) begin
          nxt_state = ST_RESOLVE;
        end
      end
      ST_RESOLVE: nxt_state = ST_EXEC;
      ST_EXEC:    if (exec_done) nxt_state = ST_OPC;
      default:    nxt_state = ST_OPC;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= ST_OPC;
      opc_ff   <= 8'h00;
      modrm_ff <= 8'h00;
      disp_ff  <= 16'h0000;
      imm_ff   <= 24'h00_0000;
      idx_ff   <= 2'h0;
      info_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      opc_ff   <= nxt_opc;
      modrm_ff <= nxt_modrm;
      disp_ff  <= nxt_disp;
      imm_ff   <= nxt_imm;
      idx_ff   <= nxt_idx;
      info_ff  <= nxt_info;
    end
  end

  // Result and clock count built once all bytes are held.
  always_comb begin
    nxt_res   = res_ff;
    nxt_valid = 1'b0;
    if (state_ff == ST_RESOLVE) begin
      nxt_valid       = 1'b1;
      nxt_res.op      = info_ff.op;
      nxt_res.form    = info_ff.form;
      nxt_res.word    = (info_ff.form == FORM_FIXED) ? 1'b1 : opc_ff[0];
      nxt_res.mem_op  = info_ff.has_modrm && mem_op;
      nxt_res.reg_fld = modrm_ff[5:3];
      nxt_res.rm_fld  = modrm_ff[2:0];
      nxt_res.level   = 8'h00;
      nxt_res.invalid = !info_ff.known;
      if (info_ff.op == OP_MUL_GRP) begin
        nxt_res.word = opc_ff[0];
      end
      nxt_res.disp = (modrm_ff[7:6] == MOD_DISP8) ? {{8{disp_ff[7]}}, disp_ff[7:0]} : disp_ff;
      nxt_res.imm  = nxt_res.word ? imm_ff[15:0] : {8'h00, imm_ff[7:0]};
      if ((info_ff.form == FORM_IMM_RM && opc_ff[1:0] == SW_SIGN_EXT) ||
          (info_ff.op == OP_SIGNED_PRODUCT_IMM && opc_ff[1])) begin
        nxt_res.imm = {{8{imm_ff[7]}}, imm_ff[7:0]};
      end
      if (info_ff.form == FORM_IMM_RM) begin
        case (modrm_ff[5:3])
          GRP_ADD: nxt_res.op = OP_ADD;
          GRP_ADC: nxt_res.op = OP_ADC;
          GRP_SUB: nxt_res.op = OP_SUB;
          GRP_SBB: nxt_res.op = OP_SBB;
          GRP_CMP: nxt_res.op = OP_CMP;
          default: nxt_res.invalid = 1'b1;
        endcase
      end
      if (info_ff.op == OP_MUL_GRP) begin
        case (modrm_ff[5:3])
          GRP_MUL:  nxt_res.op = OP_MUL;
          GRP_SIGNED_PRODUCT: nxt_res.op = OP_SIGNED_PRODUCT;
          default:  nxt_res.invalid = 1'b1;
        endcase
      end
      if (info_ff.op == OP_ENTER) begin
        nxt_res.level = imm_ff[23:16];
      end
      // far pointer from a register is reserved.
      if ((info_ff.op == OP_LDS || info_ff.op == OP_LES) && !mem_op) begin
        nxt_res.invalid = 1'b1;
      end
      // accumulator and group multiply forms pick byte and word counts; other forms share one.
      case (nxt_res.op)
        OP_LEA:   nxt_res.clocks = CLK_LEA;
        OP_LDS, OP_LES: nxt_res.clocks = CLK_PTR;
        // frame build timing by nesting level.
        OP_ENTER: nxt_res.clocks = (nxt_res.level == 8'h00) ? CLK_ENTER_L0 :
                                   (nxt_res.level == 8'h01) ? CLK_ENTER_L1 :
                                   CLK_ENTER_BASE + {nxt_res.level - 8'h01, 4'h0};
        OP_LEAVE: nxt_res.clocks = CLK_LEAVE;
        OP_FLAGS_TO_HIGH_ACC:  nxt_res.clocks = CLK_FLAGS_TO_HIGH_ACC;
        OP_HIGH_ACC_TO_FLAGS:  nxt_res.clocks = CLK_HIGH_ACC_TO_FLAGS;
        OP_AAA:   nxt_res.clocks = CLK_AAA;
        OP_DAA:   nxt_res.clocks = CLK_DAA;
        OP_AAS:   nxt_res.clocks = CLK_AAS;
        OP_DAS:   nxt_res.clocks = CLK_DAS;
        // unsigned and signed product, worst case of each range.
        OP_MUL, OP_SIGNED_PRODUCT: nxt_res.clocks = nxt_res.mem_op ?
                                          (nxt_res.word ? CLK_MUL_MW : CLK_MUL_MB) :
                                          (nxt_res.word ? CLK_MUL_RW : CLK_MUL_RB);
        OP_SIGNED_PRODUCT_IMM: nxt_res.clocks = nxt_res.mem_op ? CLK_IMULI_MEM : CLK_IMULI_REG;
        default: begin
          if (info_ff.form == FORM_IMM_ACC) begin
            nxt_res.clocks = nxt_res.word ? CLK_ACC_WORD : CLK_ACC_BYTE;
          end else if (info_ff.form == FORM_IMM_RM && nxt_res.op != OP_CMP) begin
            nxt_res.clocks = nxt_res.mem_op ? CLK_IMM_MEM : CLK_IMM_REG;
          end else begin
            nxt_res.clocks = nxt_res.mem_op ? CLK_RM_MEM : CLK_RM_REG;
          end
        end
      endcase
      if (nxt_res.invalid) begin
        nxt_res.op     = OP_NONE;
        nxt_res.clocks = CLK_INVALID;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      res_ff   <= '0;
      valid_ff <= 1'b0;
    end else begin
      res_ff   <= nxt_res;
      valid_ff <= nxt_valid;
    end
  end

  assign timer_start = (state_ff == ST_RESOLVE);

  exec_timer #(
    .CNT_W (CLK_W)
  ) u_exec_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (timer_start),
    .length  (nxt_res.clocks),
    .busy    (exec_busy),
    .done    (exec_done)
  );

  assign byte_ready = (state_ff == ST_OPC) || (state_ff == ST_MODRM) ||
                      (state_ff == ST_DISP) || (state_ff == ST_DATA);
  assign dec_valid  = valid_ff;
  assign dec_result = res_ff;

  sequence s_back_idle;
    !exec_busy ##0 byte_ready;
  endsequence

  a_lea_six: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.op == OP_LEA |-> exec_busy [*6] ##1 s_back_idle)
    else $error("offset load did not take 6 clocks");
  a_leave_eight: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.op == OP_LEAVE |-> exec_busy [*8] ##1 s_back_idle)
    else $error("frame teardown did not take 8 clocks");
  a_flag_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.op == OP_HIGH_ACC_TO_FLAGS |-> exec_busy [*3] ##1 !exec_busy)
    else $error("flag store did not take 3 clocks");
  a_ascii_minus: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.op == OP_AAS |-> exec_busy [*7] ##1 !exec_busy)
    else $error("ascii minus adjust did not take 7 clocks");
  a_ptr_reg_form: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_RESOLVE && (opc_ff == OPC_LDS || opc_ff == OPC_LES) && modrm_ff[7:6] == MOD_REG
    |=> dec_valid && dec_result.invalid && dec_result.clocks == CLK_INVALID)
    else $error("register-form pointer load not flagged");
  a_disp8_sext: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.mem_op && $past(modrm_ff[7:6]) == MOD_DISP8
    |-> dec_result.disp[15:8] == {8{dec_result.disp[7]}})
    else $error("short displacement not sign-extended");
  a_imm_sext: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.form == FORM_IMM_RM && $past(opc_ff[1:0]) == SW_SIGN_EXT
    |-> dec_result.imm[15:8] == {8{dec_result.imm[7]}})
    else $error("group immediate not sign-extended");
  a_acc_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.form == FORM_IMM_ACC
    |-> dec_result.clocks == (dec_result.word ? CLK_ACC_WORD : CLK_ACC_BYTE))
    else $error("accumulator immediate timing wrong");
  a_enter_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dec_valid && dec_result.op == OP_ENTER && dec_result.level == 8'h01
    |-> exec_busy [*8] ##1 exec_busy)
    else $error("frame build level one ended early");
  a_busy_stall: assert property (@(posedge sys_clk) disable iff (sys_rst)
    exec_busy |-> !byte_ready ##1 (exec_busy || byte_ready))
    else $error("bytes accepted during execution");

endmodule // core_arith_transfer_decode

//--- common/core_decode_pkg.sv
/*
  Shared constants and carrier types for the arithmetic and transfer opcode decoder.
  Assumes that the core clock drives all users and that each core clock is one sys_clk cycle.
*/
package core_decode_pkg;

  localparam int CLK_W = 12;

  // Whole opcodes.
  localparam logic [7:0] OPC_LEA   = 8'h8d;
  localparam logic [7:0] OPC_LDS   = 8'hc5;
  localparam logic [7:0] OPC_LES   = 8'hc4;
  localparam logic [7:0] OPC_ENTER = 8'hc8;
  localparam logic [7:0] OPC_LEAVE = 8'hc9;
  localparam logic [7:0] OPC_FLAGS_TO_HIGH_ACC  = 8'h9f;
  localparam logic [7:0] OPC_HIGH_ACC_TO_FLAGS  = 8'h9e;
  localparam logic [7:0] OPC_AAA   = 8'h37;
  localparam logic [7:0] OPC_DAA   = 8'h27;
  localparam logic [7:0] OPC_AAS   = 8'h3f;
  localparam logic [7:0] OPC_DAS   = 8'h2f;

  // Opcode bits 7:2 for the forms that carry d/w or s/w in bits 1:0.
  localparam logic [5:0] TOP6_ADD_RM   = 6'h00;
  localparam logic [5:0] TOP6_ADC_RM   = 6'h04;
  localparam logic [5:0] TOP6_SBB_RM   = 6'h06;
  localparam logic [5:0] TOP6_SUB_RM   = 6'h0a;
  localparam logic [5:0] TOP6_CMP_RM   = 6'h0e;
  localparam logic [5:0] TOP6_IMM_GRP  = 6'h20;
  localparam logic [5:0] TOP6_SIGNED_PRODUCT_IMM = 6'h1a;

  // Opcode bits 7:1 for the forms that carry only w in bit 0.
  localparam logic [6:0] TOP7_ADD_ACC = 7'h02;
  localparam logic [6:0] TOP7_ADC_ACC = 7'h0a;
  localparam logic [6:0] TOP7_CMP_ACC = 7'h1e;
  localparam logic [6:0] TOP7_MUL_GRP = 7'h7b;

  // Operand byte fields.
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8  = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG    = 2'h3;
  localparam logic [2:0] RM_DIRECT  = 3'h6;
  localparam logic [1:0] SW_WORD_TWO_BYTES = 2'h1;
  localparam logic [1:0] SW_SIGN_EXT       = 2'h3;

  // Middle field of the immediate and multiply groups.
  localparam logic [2:0] GRP_ADD  = 3'h0;
  localparam logic [2:0] GRP_ADC  = 3'h2;
  localparam logic [2:0] GRP_SBB  = 3'h3;
  localparam logic [2:0] GRP_SUB  = 3'h5;
  localparam logic [2:0] GRP_CMP  = 3'h7;
  localparam logic [2:0] GRP_MUL  = 3'h4;
  localparam logic [2:0] GRP_SIGNED_PRODUCT = 3'h5;

  // Execution clock counts.
  localparam logic [CLK_W-1:0] CLK_INVALID   = 12'h001;
  localparam logic [CLK_W-1:0] CLK_LEA       = 12'h006;
  localparam logic [CLK_W-1:0] CLK_PTR       = 12'h012;
  localparam logic [CLK_W-1:0] CLK_ENTER_L0  = 12'h00f;
  localparam logic [CLK_W-1:0] CLK_ENTER_L1  = 12'h019;
  localparam logic [CLK_W-1:0] CLK_ENTER_BASE = 12'h016;
  localparam logic [CLK_W-1:0] CLK_LEAVE     = 12'h008;
  localparam logic [CLK_W-1:0] CLK_FLAGS_TO_HIGH_ACC      = 12'h002;
  localparam logic [CLK_W-1:0] CLK_HIGH_ACC_TO_FLAGS      = 12'h003;
  localparam logic [CLK_W-1:0] CLK_AAA       = 12'h008;
  localparam logic [CLK_W-1:0] CLK_DAA       = 12'h004;
  localparam logic [CLK_W-1:0] CLK_AAS       = 12'h007;
  localparam logic [CLK_W-1:0] CLK_DAS       = 12'h004;
  localparam logic [CLK_W-1:0] CLK_RM_REG    = 12'h003;
  localparam logic [CLK_W-1:0] CLK_RM_MEM    = 12'h00a;
  localparam logic [CLK_W-1:0] CLK_IMM_REG   = 12'h004;
  localparam logic [CLK_W-1:0] CLK_IMM_MEM   = 12'h010;
  localparam logic [CLK_W-1:0] CLK_ACC_BYTE  = 12'h003;
  localparam logic [CLK_W-1:0] CLK_ACC_WORD  = 12'h004;
  localparam logic [CLK_W-1:0] CLK_MUL_RB    = 12'h01c;
  localparam logic [CLK_W-1:0] CLK_MUL_RW    = 12'h025;
  localparam logic [CLK_W-1:0] CLK_MUL_MB    = 12'h022;
  localparam logic [CLK_W-1:0] CLK_MUL_MW    = 12'h02b;
  localparam logic [CLK_W-1:0] CLK_IMULI_REG = 12'h019;
  localparam logic [CLK_W-1:0] CLK_IMULI_MEM = 12'h020;

  typedef enum logic [4:0] {
    OP_NONE, OP_LEA, OP_LDS, OP_LES, OP_ENTER, OP_LEAVE, OP_FLAGS_TO_HIGH_ACC, OP_HIGH_ACC_TO_FLAGS,
    OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_CMP, OP_AAA, OP_DAA, OP_AAS, OP_DAS,
    OP_MUL_GRP, OP_MUL, OP_SIGNED_PRODUCT, OP_SIGNED_PRODUCT_IMM
  } op_type;

  typedef enum logic [1:0] {
    FORM_FIXED, FORM_RM, FORM_IMM_RM, FORM_IMM_ACC
  } form_type;

  typedef struct packed {
    logic       known;
    op_type     op;
    form_type   form;
    logic       has_modrm;
    logic [1:0] imm_bytes;
  } opc_info_type;

  typedef struct packed {
    op_type           op;
    form_type         form;
    logic             word;
    logic             mem_op;
    logic [2:0]       reg_fld;
    logic [2:0]       rm_fld;
    logic [15:0]      disp;
    logic [15:0]      imm;
    logic [7:0]       level;
    logic [CLK_W-1:0] clocks;
    logic             invalid;
  } decode_result_type;

endpackage

//--- logic/operand_len.sv
/*
  Operand byte length logic: displacement byte count and memory flag from mod and r/m.
  Assumes a purely combinational use by the decoder.
*/
`timescale 1ns/100ps
module operand_len
  import core_decode_pkg::*;
(
  // Operand byte.
  input  wire logic [7:0] modrm,
  // Results.
  output logic [1:0]      disp_bytes,
  output logic            mem_op
);

  always_comb begin
    mem_op     = (modrm[7:6] != MOD_REG);
    disp_bytes = 2'h0;
    case (modrm[7:6])
      MOD_NODISP: disp_bytes = (modrm[2:0] == RM_DIRECT) ? 2'h2 : 2'h0;
      MOD_DISP8:  disp_bytes = 2'h1;
      MOD_DISP16: disp_bytes = 2'h2;
      default:    disp_bytes = 2'h0;
    endcase
  end

endmodule // operand_len

//--- logic/exec_timer.sv
/*
  Execution clock timer: holds busy for the loaded number of cycles, pulsing done in the last of them.
  Assumes start only arrives while idle and a count of at least one.
*/
`timescale 1ns/100ps
module exec_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Control.
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] length,
  // Status.
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // Counts below 12 bits cannot hold the longest frame build time.
  if (CNT_W < 12) begin : g_width_check
    $error("exec_timer needs at least 12 count bits");
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = length;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == CNT_W'(1));

  a_done_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
    done |=> !busy) else $error("timer still busy after done");

endmodule // exec_timer

//--- dv/core_arith_transfer_decode_test.sv
/*
  Self-checking bench for the opcode decoder and its execution timer.
  Assumes one byte is taken per edge while byte_valid and byte_ready are high.
*/
`timescale 1ns/100ps
module core_arith_transfer_decode_test
  import core_decode_pkg::*;
;
  logic              sys_clk;
  logic              sys_rst;
  logic              byte_valid;
  logic [7:0]        byte_data;
  logic              byte_ready;
  logic              dec_valid;
  decode_result_type dec_result;
  logic              exec_busy;
  logic              exec_done;
  int                fails;
  int                samples_checked;

  core_arith_transfer_decode dut (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .byte_valid(byte_valid),
    .byte_data (byte_data),
    .byte_ready(byte_ready),
    .dec_valid (dec_valid),
    .dec_result(dec_result),
    .exec_busy (exec_busy),
    .exec_done (exec_done)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Sends n bytes, lowest first, then checks latency, result and busy span.
  task automatic run(input logic [31:0] b, input int n, input op_type eo,
                     input logic [11:0] ec, input int ei);
    int k;
    int w;
    int d;
    for (k = 0; k < n; k++) begin
      @(negedge sys_clk);
      byte_valid = 1'b1;
      byte_data  = b[8*k+:8];
      for (w = 0; w < 99 && byte_ready !== 1'b1; w++) begin
        @(negedge sys_clk);
      end
    end
    @(negedge sys_clk);
    byte_valid = 1'b0;
    chk(16'(dec_valid), 16'h0000);
    @(negedge sys_clk);
    chk(16'(dec_valid), 16'h0001);
    chk(16'(dec_result.invalid), 16'(ei));
    if (ei == 0) begin
      chk(16'(dec_result.op), 16'(eo));
    end
    chk(16'(dec_result.clocks), 16'(ec));
    d = 0;
    for (w = 0; w < 99 && exec_busy === 1'b1; w++) begin
      if (exec_done === 1'b1) begin
        d = w + 1;
      end
      @(negedge sys_clk);
    end
    chk(16'(w), 16'(ec));
    chk(16'(d), 16'(ec));
  endtask

  task automatic t_transfer;
    run(32'h0080_468d, 3, OP_LEA, 12'h006, 0);
    chk(dec_result.disp, 16'hff80);
    chk(16'({dec_result.mem_op, dec_result.reg_fld, dec_result.rm_fld}), 16'h0046);
    run(32'h0000_07c5, 2, OP_LDS, 12'h012, 0);
    run(32'h0000_1fc4, 2, OP_LES, 12'h012, 0);
    run(32'h0000_c0c5, 2, OP_NONE, 12'h001, 1);
    run(32'h0000_002c, 1, OP_NONE, 12'h001, 1);
  endtask

  task automatic t_frame;
    run(32'h0012_34c8, 4, OP_ENTER, 12'h00f, 0);
    run(32'h0112_34c8, 4, OP_ENTER, 12'h019, 0);
    run(32'h0312_34c8, 4, OP_ENTER, 12'h036, 0);
    chk(16'(dec_result.level), 16'h0003);
    run(32'h0000_00c9, 1, OP_LEAVE, 12'h008, 0);
  endtask

  task automatic t_fixed;
    run(32'h0000_009f, 1, OP_FLAGS_TO_HIGH_ACC, 12'h002, 0);
    run(32'h0000_009e, 1, OP_HIGH_ACC_TO_FLAGS, 12'h003, 0);
    run(32'h0000_0037, 1, OP_AAA, 12'h008, 0);
    run(32'h0000_0027, 1, OP_DAA, 12'h004, 0);
    run(32'h0000_003f, 1, OP_AAS, 12'h007, 0);
    run(32'h0000_002f, 1, OP_DAS, 12'h004, 0);
  endtask

  task automatic t_twoop;
    run(32'h0000_c100, 2, OP_ADD, 12'h003, 0);
    run(32'h1234_0603, 4, OP_ADD, 12'h00a, 0);
    run(32'h0000_0712, 2, OP_ADC, 12'h00a, 0);
    run(32'h0000_c019, 2, OP_SBB, 12'h003, 0);
    run(32'h0000_072a, 2, OP_SUB, 12'h00a, 0);
    run(32'h0000_c03b, 2, OP_CMP, 12'h003, 0);
  endtask

  task automatic t_imm;
    run(32'h0005_c080, 3, OP_ADD, 12'h004, 0);
    chk(16'({FORM_IMM_RM, 1'b0}), 16'({dec_result.form, dec_result.word}));
    run(32'h1234_d081, 4, OP_ADC, 12'h004, 0);
    chk(dec_result.imm, 16'h1234);
    run(32'h0005_1f80, 3, OP_SBB, 12'h010, 0);
    run(32'h0080_e883, 3, OP_SUB, 12'h004, 0);
    chk(dec_result.imm, 16'hff80);
    run(32'h0005_3f80, 3, OP_CMP, 12'h00a, 0);
    run(32'h0000_0504, 2, OP_ADD, 12'h003, 0);
    run(32'h0012_3405, 3, OP_ADD, 12'h004, 0);
    run(32'h0000_0514, 2, OP_ADC, 12'h003, 0);
    run(32'h0012_343d, 3, OP_CMP, 12'h004, 0);
  endtask

  task automatic t_mul;
    run(32'h0000_e1f6, 2, OP_MUL, 12'h01c, 0);
    run(32'h0000_e1f7, 2, OP_MUL, 12'h025, 0);
    run(32'h0000_21f7, 2, OP_MUL, 12'h02b, 0);
    chk(16'({dec_result.mem_op, dec_result.word}), 16'h0003);
    run(32'h0000_e9f6, 2, OP_SIGNED_PRODUCT, 12'h01c, 0);
    run(32'h1234_c069, 4, OP_SIGNED_PRODUCT_IMM, 12'h019, 0);
    run(32'h0080_076b, 3, OP_SIGNED_PRODUCT_IMM, 12'h020, 0);
    chk(dec_result.imm, 16'hff80);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    conclude();
  end

  initial begin
    fails           = 0;
    samples_checked = 0;
    sys_rst         = 1'b1;
    byte_valid      = 1'b0;
    byte_data       = 8'h00;
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(16'({byte_ready, dec_valid, exec_busy}), 16'h0004);
    t_transfer();
    t_frame();
    t_fixed();
    t_twoop();
    t_imm();
    t_mul();
    conclude();
  end
endmodule // core_arith_transfer_decode_test
